// ===== shared/cdw_defs.vh
// Purpose: constants of the chaining descriptor walker
// Assumes: 32-bit AHB-Lite register bus, 64-bit host addresses
// Notes:   register offsets compare against haddr[7:0]
`ifndef CDW_DEFS_VH
`define CDW_DEFS_VH

// register byte offsets
`define CDW_OFF_CTRL      8'h00
`define CDW_OFF_BASE_HI   8'h04
`define CDW_OFF_BASE_LO   8'h08
`define CDW_OFF_LAST      8'h0c
`define CDW_OFF_STATUS    8'h10
`define CDW_OFF_IRQ_STAT  8'h14
`define CDW_OFF_IRQ_MASK  8'h18

// control register fields
`define CDW_CTRL_WB_BIT   17
`define CDW_CTRL_IE_BIT   16
`define CDW_CNT_W         16

// status register fields
`define CDW_STAT_BUSY_BIT 16

// descriptor table layout in host memory
`define CDW_TBL_DONE_OFF  64'h0000_0000_0000_000c
`define CDW_TBL_DESC_OFF  64'h0000_0000_0000_0010
`define CDW_DESC_DWORDS   2'h3
`define CDW_LEN_W         16
`define CDW_DESC_WB_BIT   17
`define CDW_DESC_IE_BIT   16

// interrupt events
`define CDW_EV_W          2
`define CDW_EV_DESC       0
`define CDW_EV_CHAIN      1

// reset values
`define CDW_RST_WORD      32'h0000_0000
`define CDW_RST_IDX       16'h0000

`endif

// ===== hw/cdw_irq.v
// Purpose: sticky event status, mask and level interrupt
// Assumes: events are one-cycle pulses on hclk
// Notes:   write one to clear; a set in the same cycle wins
`timescale 1ns/1ns
module cdw_irq #(
    parameter N = 2
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire [N-1:0] ev_set,
    input  wire         clr_we,
    input  wire [N-1:0] clr_data,
    input  wire         mask_we,
    input  wire [N-1:0] mask_data,
    output wire [N-1:0] stat,
    output wire [N-1:0] mask,
    output wire         irq
);
    reg [N-1:0] stat_reg;
    reg [N-1:0] stat_next;
    reg [N-1:0] mask_reg;
    reg         irq_reg;

    always @* begin
        stat_next = stat_reg;
        if (clr_we) begin
            stat_next = stat_next & ~clr_data;
        end
        stat_next = stat_next | ev_set;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_reg <= {N{1'b0}};
            mask_reg <= {N{1'b0}};
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            if (mask_we) begin
                mask_reg <= mask_data;
            end
            irq_reg <= |(stat_next & (mask_we ? mask_data : mask_reg));
        end
    end

    assign stat = stat_reg;
    assign mask = mask_reg;
    assign irq  = irq_reg;
endmodule // cdw_irq

// ===== hw/cdw_walker.v
// Purpose: descriptor walker of an endpoint chaining DMA engine
// Assumes: one clock hclk; host memory reached by a request/ack port;
//          data mover reached by a start/done handshake
// Notes:   registers on AHB-Lite, zero wait states, always OKAY
`timescale 1ns/1ns
`include "cdw_defs.vh"
module cdw_walker (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    output wire        mem_req,
    output wire        mem_we,
    output wire [63:0] mem_addr,
    output wire [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata,
    output wire        xfer_start,
    output wire [15:0] xfer_len,
    output wire [31:0] xfer_ep_addr,
    output wire [63:0] xfer_rc_addr,
    input  wire        xfer_done,
    output wire        msi_req,
    input  wire        msi_ack,
    output wire        irq
);
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_FETCH = 3'd1;
    localparam [2:0] S_XFER  = 3'd2;
    localparam [2:0] S_WAIT  = 3'd3;
    localparam [2:0] S_WB    = 3'd4;
    localparam [2:0] S_MSI   = 3'd5;
    localparam [2:0] S_NEXT  = 3'd6;

    // descriptor address within the table
    function [63:0] desc_addr;
        input [63:0] base;
        input [15:0] k;
        input [1:0]  dw;
        begin
            desc_addr = base + `CDW_TBL_DESC_OFF
                      + {44'h0, k, 4'h0} + {60'h0, dw, 2'b00};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register bus
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg  [31:0] hrdata_reg;
    reg         wb_en_reg;
    reg         ie_reg;
    reg  [15:0] desc_cnt_reg;
    reg  [31:0] base_hi_reg;
    reg  [31:0] base_lo_reg;
    reg  [15:0] last_valid_reg;
    reg  [15:0] last_done_index_reg;
    reg  [31:0] rd_val;
    wire        addr_phase;
    wire        wr_last;
    wire        wr_irq_stat;
    wire        wr_irq_mask;
    wire [`CDW_EV_W-1:0] irq_stat;
    wire [`CDW_EV_W-1:0] irq_mask;
    wire        busy;
    wire        start;

    assign addr_phase = hsel & hready & htrans[1];
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_reg;

    assign wr_last     = wr_pend_reg & (wr_addr_reg == `CDW_OFF_LAST);
    assign wr_irq_stat = wr_pend_reg & (wr_addr_reg == `CDW_OFF_IRQ_STAT);
    assign wr_irq_mask = wr_pend_reg & (wr_addr_reg == `CDW_OFF_IRQ_MASK);
    assign start = wr_last & ~busy;

    always @* begin
        rd_val = `CDW_RST_WORD;
        if (haddr[7:0] == `CDW_OFF_CTRL) begin
            rd_val[`CDW_CTRL_WB_BIT] = wb_en_reg;
            rd_val[`CDW_CTRL_IE_BIT] = ie_reg;
            rd_val[`CDW_CNT_W-1:0]   = desc_cnt_reg;
        end else if (haddr[7:0] == `CDW_OFF_BASE_HI) begin
            rd_val = base_hi_reg;
        end else if (haddr[7:0] == `CDW_OFF_BASE_LO) begin
            rd_val = base_lo_reg;
        end else if (haddr[7:0] == `CDW_OFF_LAST) begin
            rd_val[`CDW_CNT_W-1:0] = last_valid_reg;
        end else if (haddr[7:0] == `CDW_OFF_STATUS) begin
            rd_val[`CDW_STAT_BUSY_BIT] = busy;
            rd_val[`CDW_CNT_W-1:0]     = last_done_index_reg;
        end else if (haddr[7:0] == `CDW_OFF_IRQ_STAT) begin
            rd_val[`CDW_EV_W-1:0] = irq_stat;
        end else if (haddr[7:0] == `CDW_OFF_IRQ_MASK) begin
            rd_val[`CDW_EV_W-1:0] = irq_mask;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg    <= 1'b0;
            wr_addr_reg    <= 8'h00;
            hrdata_reg     <= `CDW_RST_WORD;
            wb_en_reg      <= 1'b0;
            ie_reg         <= 1'b0;
            desc_cnt_reg   <= `CDW_RST_IDX;
            base_hi_reg    <= `CDW_RST_WORD;
            base_lo_reg    <= `CDW_RST_WORD;
            last_valid_reg <= `CDW_RST_IDX;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[7:0];
            end
            // read data sampled in the address phase
            if (addr_phase & ~hwrite) begin
                hrdata_reg <= rd_val;
            end
            // set-up is frozen while a chain runs
            if (wr_pend_reg & ~busy) begin
                if (wr_addr_reg == `CDW_OFF_CTRL) begin
                    wb_en_reg    <= hwdata[`CDW_CTRL_WB_BIT];
                    ie_reg       <= hwdata[`CDW_CTRL_IE_BIT];
                    desc_cnt_reg <= hwdata[`CDW_CNT_W-1:0];
                end else if (wr_addr_reg == `CDW_OFF_BASE_HI) begin
                    base_hi_reg <= hwdata;
                end else if (wr_addr_reg == `CDW_OFF_BASE_LO) begin
                    base_lo_reg <= hwdata;
                end else if (wr_addr_reg == `CDW_OFF_LAST) begin
                    last_valid_reg <= hwdata[`CDW_CNT_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // descriptor walk
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [15:0] k_reg;
    reg  [15:0] k_next;
    reg  [1:0]  dw_reg;
    reg  [1:0]  dw_next;
    reg  [31:0] d0_reg;
    reg  [31:0] d1_reg;
    reg  [31:0] d2_reg;
    reg  [31:0] d3_reg;
    reg  [63:0] mem_addr_reg;
    reg  [31:0] mem_wdata_reg;
    reg  [15:0] last_done_next;
    reg  [`CDW_EV_W-1:0] ev_next;
    reg  [`CDW_EV_W-1:0] ev_reg;
    wire [63:0] base;
    wire        wb_on;
    wire        ie_on;

    assign base = {base_hi_reg, base_lo_reg};
    assign wb_on = d0_reg[`CDW_DESC_WB_BIT] | wb_en_reg;
    assign ie_on = d0_reg[`CDW_DESC_IE_BIT] | ie_reg;
    assign busy  = (state_reg != S_IDLE);

    always @* begin
        state_next     = state_reg;
        k_next         = k_reg;
        dw_next        = dw_reg;
        last_done_next = last_done_index_reg;
        ev_next        = {`CDW_EV_W{1'b0}};
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    k_next     = `CDW_RST_IDX;
                    dw_next    = 2'h0;
                    state_next = S_FETCH;
                end
            end
            S_FETCH: begin
                if (mem_ack) begin
                    if (dw_reg == `CDW_DESC_DWORDS) begin
                        state_next = S_XFER;
                    end else begin
                        dw_next = dw_reg + 2'h1;
                    end
                end
            end
            S_XFER: begin
                state_next = S_WAIT;
            end
            S_WAIT: begin
                if (xfer_done) begin
                    last_done_next = k_reg;
                    ev_next[`CDW_EV_DESC] = 1'b1;
                    if (wb_on) begin
                        state_next = S_WB;
                    end else if (ie_on) begin
                        state_next = S_MSI;
                    end else begin
                        state_next = S_NEXT;
                    end
                end
            end
            S_WB: begin
                if (mem_ack) begin
                    state_next = ie_on ? S_MSI : S_NEXT;
                end
            end
            S_MSI: begin
                if (msi_ack) begin
                    state_next = S_NEXT;
                end
            end
            S_NEXT: begin
                if (k_reg == last_valid_reg) begin
                    ev_next[`CDW_EV_CHAIN] = 1'b1;
                    state_next = S_IDLE;
                end else begin
                    k_next     = k_reg + 16'h0001;
                    dw_next    = 2'h0;
                    state_next = S_FETCH;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg           <= S_IDLE;
            k_reg               <= `CDW_RST_IDX;
            dw_reg              <= 2'h0;
            d0_reg              <= `CDW_RST_WORD;
            d1_reg              <= `CDW_RST_WORD;
            d2_reg              <= `CDW_RST_WORD;
            d3_reg              <= `CDW_RST_WORD;
            mem_addr_reg        <= 64'h0;
            mem_wdata_reg       <= `CDW_RST_WORD;
            last_done_index_reg <= `CDW_RST_IDX;
            ev_reg              <= {`CDW_EV_W{1'b0}};
        end else begin
            state_reg           <= state_next;
            k_reg               <= k_next;
            dw_reg              <= dw_next;
            last_done_index_reg <= last_done_next;
            ev_reg              <= ev_next;
            if ((state_reg == S_FETCH) && mem_ack) begin
                case (dw_reg)
                    2'h0: d0_reg <= mem_rdata;
                    2'h1: d1_reg <= mem_rdata;
                    2'h2: d2_reg <= mem_rdata;
                    default: d3_reg <= mem_rdata;
                endcase
            end
            if (state_next == S_WB) begin
                mem_addr_reg <= base + `CDW_TBL_DONE_OFF;
            end else begin
                mem_addr_reg <= desc_addr(base, k_next, dw_next);
            end
            mem_wdata_reg <= {16'h0000, last_done_next};
        end
    end

    // only the done slot is ever written
    assign mem_req   = (state_reg == S_FETCH) | (state_reg == S_WB);
    assign mem_we    = (state_reg == S_WB);
    assign mem_addr  = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;

    assign xfer_start = (state_reg == S_XFER);
    assign xfer_len = d0_reg[`CDW_LEN_W-1:0];
    assign xfer_ep_addr = d1_reg;
    assign xfer_rc_addr = {d2_reg, d3_reg};
    assign msi_req = (state_reg == S_MSI);

    ////////////////////////////////////////////////////////////////////
    // interrupt status
    cdw_irq #(
        .N (`CDW_EV_W)
    ) u_irq (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ev_set    (ev_reg),
        .clr_we    (wr_irq_stat),
        .clr_data  (hwdata[`CDW_EV_W-1:0]),
        .mask_we   (wr_irq_mask),
        .mask_data (hwdata[`CDW_EV_W-1:0]),
        .stat      (irq_stat),
        .mask      (irq_mask),
        .irq       (irq)
    );
endmodule // cdw_walker

// ===== testbench/cdw_asserts.sv
// Purpose: protocol checks on the host memory, transfer and msi ports
// Assumes: one clock hclk, hresetn asynchronous active low
// Notes:   descriptor dwords are captured as the host returns them
`timescale 1ns/1ns
module cdw_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic        xfer_start,
    input wire logic [15:0] xfer_len,
    input wire logic [31:0] xfer_ep_addr,
    input wire logic [63:0] xfer_rc_addr,
    input wire logic        xfer_done,
    input wire logic        msi_req,
    input wire logic        msi_ack
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [31:0] d0_reg, d1_reg, d2_reg, d3_reg;
    wire rd_done = mem_req && mem_ack && !mem_we;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {d0_reg, d1_reg, d2_reg, d3_reg} <= '0;
        end else if (rd_done) begin
            case (mem_addr[3:2])
                2'h0: d0_reg <= mem_rdata;
                2'h1: d1_reg <= mem_rdata;
                2'h2: d2_reg <= mem_rdata;
                default: d3_reg <= mem_rdata;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_req_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
            && $stable(mem_we) && $stable(mem_wdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_fetch_step;
        rd_done && mem_addr[3:2] != 2'h3 |=> mem_req && !mem_we
            && mem_addr == $past(mem_addr) + 64'h4;
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("bad step");
    property p_start;
        rd_done && mem_addr[3:2] == 2'h3 |=> xfer_start;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_start_once;
        xfer_start |=> !xfer_start [*4];
    endproperty
    a_start_once: assert property (p_start_once) else $error("restart");
    property p_fields;
        xfer_start |-> xfer_len == d0_reg[15:0] && xfer_ep_addr == d1_reg
            && xfer_rc_addr == {d2_reg, d3_reg};
    endproperty
    a_fields: assert property (p_fields) else $error("bad fields");
    property p_wb_place;
        mem_req && mem_we |-> mem_addr[3:0] == 4'hc
            && mem_wdata[31:16] == 16'h0;
    endproperty
    a_wb_place: assert property (p_wb_place) else $error("bad write");
    property p_msi_hold;
        msi_req && !msi_ack |=> msi_req;
    endproperty
    a_msi_hold: assert property (p_msi_hold) else $error("msi dropped");
    property p_msi_cause;
        $rose(msi_req) |-> $past(xfer_done || (mem_ack && mem_we && mem_req));
    endproperty
    a_msi_cause: assert property (p_msi_cause) else $error("early msi");
    c_start: cover property (xfer_start);
    c_wb: cover property (mem_req && mem_we && mem_ack);
    c_msi: cover property (msi_req && msi_ack);
endmodule // cdw_asserts

bind cdw_walker cdw_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .xfer_start(xfer_start), .xfer_len(xfer_len),
    .xfer_ep_addr(xfer_ep_addr), .xfer_rc_addr(xfer_rc_addr),
    .xfer_done(xfer_done), .msi_req(msi_req), .msi_ack(msi_ack));

// ===== testbench/cdw_host_model.sv
// Purpose: host memory, data mover and msi receiver beside the walker
// Assumes: table held inside one 4 KByte page
// Notes:   random answer delays; read data scrambled outside acks
`timescale 1ns/1ns
module cdw_host_model (
    input  wire logic        hclk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [63:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack = 1'b0,
    output logic [31:0]      mem_rdata = 32'h0,
    input  wire logic        xfer_start,
    output logic             xfer_done = 1'b0,
    input  wire logic        msi_req,
    output logic             msi_ack = 1'b0
);
    logic [31:0] mem [0:1023];
    int          wb_n = 0, msi_n = 0, xf_n = 0, dly = 0;
    always @(posedge hclk) begin
        mem_ack   <= mem_req && !mem_ack && ($urandom % 3 != 0);
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && !mem_we)
            mem_rdata <= mem[mem_addr[11:2]];
        if (mem_req && mem_ack && mem_we) begin
            mem[mem_addr[11:2]] <= mem_wdata;
            wb_n++;
        end
        msi_ack <= msi_req && !msi_ack && ($urandom % 2 != 0);
        if (msi_req && msi_ack)
            msi_n++;
        xfer_done <= (dly == 1);
        if (xfer_start) begin
            dly = 1 + $urandom % 4;
            xf_n++;
        end else if (dly != 0)
            dly--;
    end
endmodule // cdw_host_model

// ===== testbench/testbench.sv
// Purpose: random descriptor chains through the walker
// Assumes: zero wait AHB-Lite slave, host model answers randomly
// Notes:   expectations from descriptor and control enable bits
`timescale 1ns/1ns
`include "cdw_defs.vh"
module testbench;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    wire         hreadyout, hresp, mem_req, mem_we, mem_ack, xfer_start;
    wire         xfer_done, msi_req, msi_ack, irq;
    wire [31:0]  hrdata, mem_wdata, mem_rdata, xfer_ep_addr;
    wire [63:0]  mem_addr, xfer_rc_addr;
    wire [15:0]  xfer_len;
    int          failures = 0, n_compared = 0;
    always #25 hclk = ~hclk;
    cdw_walker dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .xfer_start(xfer_start), .xfer_len(xfer_len),
        .xfer_ep_addr(xfer_ep_addr), .xfer_rc_addr(xfer_rc_addr),
        .xfer_done(xfer_done), .msi_req(msi_req), .msi_ack(msi_ack),
        .irq(irq));
    cdw_host_model host (.hclk(hclk), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .xfer_start(xfer_start),
        .xfer_done(xfer_done), .msi_req(msi_req), .msi_ack(msi_ack));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        int i;
        i = 0;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 40);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 40);
        if (i >= 40) begin failures++; give_verdict; end
        rd = hrdata;
    endtask
    function automatic int on(input logic [31:0] d, input logic [31:0] c,
                              input int b);
        return (d[b] | c[b]) ? 1 : 0;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] v, base, hi, ctrl, ehdr, tbl [0:15];
    logic [7:0]  ra [0:4] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c};
    int          n, k, ewb, emsi, w0, m0, x0, hx;
    int          xi = 0;
    always @(posedge hclk) begin
        if (hresetn && xfer_start) begin
            chk(xfer_len, tbl[4 * xi][15:0]);
            chk(xfer_ep_addr, tbl[4 * xi + 1]);
            chk(xfer_rc_addr[63:32], tbl[4 * xi + 2]);
            chk(xfer_rc_addr[31:0], tbl[4 * xi + 3]);
            xi++;
        end
    end
    initial begin
        v = $urandom(53);
        hsel <= 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (k = 0; k < 5; k++) begin
            bus(ra[k], 0, 0, v);
            chk(v, 0);
            chk(hresp, 0);
        end
        for (int it = 0; it < 12; it++) begin
            n = 1 + $urandom % 4;
            ctrl = {14'h0, it[1:0], 16'(n)};
            base = ($urandom % 48) * 64;
            hi = $urandom;
            hx = base[11:2];
            ehdr = 32'hdead_beef;
            host.mem[hx + 3] = ehdr;
            {ewb, emsi} = 0;
            xi = 0;
            for (k = 0; k < 4 * n; k++) begin
                tbl[k] = $urandom;
                host.mem[hx + 4 + k] = tbl[k];
                if (k % 4 == 0) begin
                    ewb += on(tbl[k], ctrl, 17);
                    emsi += on(tbl[k], ctrl, 16);
                    if (on(tbl[k], ctrl, 17) == 1) ehdr = k / 4;
                end
            end
            {w0, m0, x0} = {host.wb_n, host.msi_n, host.xf_n};
            bus(`CDW_OFF_IRQ_MASK, 1, it[2] ? 3 : 0, v);
            bus(`CDW_OFF_CTRL, 1, ctrl, v);
            bus(`CDW_OFF_BASE_HI, 1, hi, v);
            bus(`CDW_OFF_BASE_LO, 1, base, v);
            bus(`CDW_OFF_LAST, 1, n - 1, v);
            bus(`CDW_OFF_BASE_LO, 1, ~base, v);
            k = 0;
            do begin bus(`CDW_OFF_STATUS, 0, 0, v); k++; end
                while (v[16] !== 1'b0 && k < 300);
            if (v[16] !== 1'b0) begin failures++; give_verdict; end
            chk(v, n - 1);
            bus(`CDW_OFF_BASE_LO, 0, 0, v);
            chk(v, base);
            chk(host.xf_n - x0, n);
            chk(host.wb_n - w0, ewb);
            chk(host.msi_n - m0, emsi);
            chk(host.mem[hx + 3], ehdr);
            for (k = 0; k < 4 * n; k++) chk(host.mem[hx + 4 + k], tbl[k]);
            bus(`CDW_OFF_IRQ_STAT, 0, 0, v);
            chk(v, 3);
            chk(irq, it[2]);
            bus(`CDW_OFF_IRQ_MASK, 1, 3, v);
            bus(`CDW_OFF_IRQ_STAT, 1, 3, v);
            bus(`CDW_OFF_IRQ_STAT, 0, 0, v);
            chk(v, 0);
            chk(irq, 0);
        end
        bus(8'h1c, 1, 32'hffff_ffff, v);
        bus(8'h1c, 0, 0, v);
        chk(v, 0);
        give_verdict;
    end
endmodule // testbench
